// ---- hdl/lcr_cycle_timer.sv ----
// Cycle timer offset counter with internal or external rollover
module lcr_cycle_timer #(
   parameter int ROLL_TICKS = lcr_pkg::CYCLE_TICKS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic tick_i,
   input wire logic count_enable_i,
   input wire logic ext_select_i,
   input wire logic ext_cycle_i,
   // Status
   output logic [lcr_pkg::OFFSET_W-1:0] offset_o,
   output logic rollover_o
);

   localparam logic [lcr_pkg::OFFSET_W-1:0] LAST = lcr_pkg::OFFSET_W'(ROLL_TICKS - 1);

   logic [lcr_pkg::OFFSET_W-1:0] offset_reg, offset_next;
   logic roll_reg, roll_next;
   logic ext_prev_reg, ext_prev_next;
   logic ext_edge;

   // ****************************************
   // Offset counter
   // ****************************************
   // External rollover acts on the rising edge so a long pulse gives one cycle
   always_comb
   begin
      ext_prev_next = ext_cycle_i;
      ext_edge = ext_cycle_i & ~ext_prev_reg;
      offset_next = offset_reg;
      roll_next = 1'b0;
      if (count_enable_i)
      begin
         if (ext_select_i && ext_edge)
         begin
            offset_next = '0;
            roll_next = 1'b1;
         end
         else if (tick_i)
         begin
            // Without the external source the counter wraps by itself
            if (!ext_select_i && offset_reg == LAST)
            begin
               offset_next = '0;
               roll_next = 1'b1;
            end
            else if (offset_reg != '1)
               offset_next = offset_reg + 1'b1;
         end
      end
   end

   // Register stage
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         offset_reg <= '0;
         roll_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end
      else
      begin
         offset_reg <= offset_next;
         roll_reg <= roll_next;
         ext_prev_reg <= ext_prev_next;
      end
   end

   assign offset_o = offset_reg;
   assign rollover_o = roll_reg;

   // ****************************************
   // Checks
   // ****************************************
   hold_when_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !count_enable_i |=> $stable(offset_reg) && !roll_reg)
      else $error("Offset moved while counting disabled");

   internal_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      count_enable_i && !ext_select_i && tick_i && offset_reg == LAST |=> offset_reg == '0 && roll_reg)
      else $error("Internal rollover missed at last tick");
endmodule

// ---- hdl/lcr_link_config.sv ----
// Link configuration register bank with Wishbone slave, cycle timer and fairness limiter
// Function
// - Channel mask resets to all ones
// - Serial bus reset keeps channel mask
// - Bus resets copy mask into CSR
// - Fairness bits 31..8 read zero
// - Priority limit caps requests per interval
// - Set and clear addresses change control bits
// - Only listed control bits are writable
// - Rollover external or after 3072 ticks
// - Overlong cycle clears and blocks root bit
// - Count enable gates cycle offset counting
// - Lock cleared by global reset, forces filter
//
// The Wishbone slave port was chosen for this implementation.
module lcr_link_config (
   // Clock and resets
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic soft_reset_i,
   input wire logic global_reset_signal_i,
   input wire logic host_bus_reset_i,
   input wire logic serial_bus_reset_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Link core events
   input wire logic overlong_cycle_flag_i,
   input wire logic external_cycle_input_i,
   input wire logic cycle_tick_i,
   input wire logic prio_req_issued_i,
   input wire logic fairness_interval_start_i,
   // Configuration outputs
   output logic [31:0] channels_available_lo_o,
   output logic [7:0] priority_limit_o,
   output logic priority_request_allowed_o,
   output logic external_rollover_select_o,
   output logic root_cycle_generator_o,
   output logic cycle_count_enable_o,
   output logic accept_phy_packets_o,
   output logic accept_self_id_packets_o,
   output logic sync_filter_lock_o,
   // Cycle timer outputs
   output logic [lcr_pkg::OFFSET_W-1:0] cycle_offset_o,
   output logic cycle_start_o
);

   // ****************************************
   // Helper functions
   // ****************************************
   // Byte lane enables widened to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++)
         m[i*8 +: 8] = {8{sel[i]}};
      return m;
   endfunction

   // Address match on the word, ignoring the two low address bits
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      return adr[7:2] == ofs[7:2];
   endfunction

   // ****************************************
   // State
   // ****************************************
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic [31:0] mask_reg, mask_next;
   logic [31:0] csr_reg, csr_next;
   logic [7:0] fair_reg, fair_next;
   logic [7:0] pcount_reg, pcount_next;
   logic allow_reg, allow_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic cstart_reg, cstart_next;
   logic wr_take;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic rollover;

   // ****************************************
   // Wishbone handshake and read data
   // ****************************************
   // Ack comes one cycle after the request and drops the cycle after;
   // writes land at the ack edge so a held request is written exactly once
   always_comb
   begin
      ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
      wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
      wmask = lane_mask(wb_sel_i);
      wbits = wb_dat_i & wmask;
      rdat_next = rdat_reg;
      if (ack_next)
      begin
         if (hit(wb_adr_i, lcr_pkg::OFS_CHAN_MASK_LO))
            rdat_next = mask_reg;
         else if (hit(wb_adr_i, lcr_pkg::OFS_FAIRNESS))
            rdat_next = {24'h00_0000, fair_reg};
         else if (hit(wb_adr_i, lcr_pkg::OFS_CTRL_SET) || hit(wb_adr_i, lcr_pkg::OFS_CTRL_CLEAR))
            rdat_next = ctrl_reg;
         else
            rdat_next = lcr_pkg::UNMAPPED_DATA;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         rdat_reg <= '0;
      end
      else
      begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   // ****************************************
   // Channel mask and its CSR copy
   // ****************************************
   // Serial bus reset only triggers the copy; the mask itself survives it
   always_comb
   begin
      mask_next = mask_reg;
      if (soft_reset_i)
         mask_next = lcr_pkg::CHAN_MASK_RESET;
      else if (wr_take && hit(wb_adr_i, lcr_pkg::OFS_CHAN_MASK_LO))
         mask_next = (mask_reg & ~wmask) | wbits;
      csr_next = csr_reg;
      if (global_reset_signal_i || host_bus_reset_i || serial_bus_reset_i)
         csr_next = mask_reg;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mask_reg <= lcr_pkg::CHAN_MASK_RESET;
         csr_reg <= lcr_pkg::CHAN_MASK_RESET;
      end
      else
      begin
         mask_reg <= mask_next;
         csr_reg <= csr_next;
      end
   end

   // ****************************************
   // Fairness limit and request counter
   // ****************************************
   // Allowed is registered from the next count, so it drops on the edge that counts the last request
   always_comb
   begin
      fair_next = fair_reg;
      if (soft_reset_i)
         fair_next = lcr_pkg::FAIRNESS_RESET;
      else if (wr_take && hit(wb_adr_i, lcr_pkg::OFS_FAIRNESS) && wb_sel_i[0])
         fair_next = wb_dat_i[7:0];
      pcount_next = pcount_reg;
      if (fairness_interval_start_i)
         pcount_next = '0;
      else if (prio_req_issued_i && allow_reg)
         pcount_next = pcount_reg + 8'h01;
      allow_next = pcount_next < fair_next;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fair_reg <= lcr_pkg::FAIRNESS_RESET;
         pcount_reg <= '0;
         allow_reg <= 1'b0;
      end
      else
      begin
         fair_reg <= fair_next;
         pcount_reg <= pcount_next;
         allow_reg <= allow_next;
      end
   end

   // ****************************************
   // Link control set/clear register
   // ****************************************
   // Hardware clear of the root bit beats any software set in the same cycle
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (wr_take && hit(wb_adr_i, lcr_pkg::OFS_CTRL_SET))
         ctrl_next = ctrl_reg | (wbits & lcr_pkg::CTRL_SET_MASK);
      else if (wr_take && hit(wb_adr_i, lcr_pkg::OFS_CTRL_CLEAR))
         ctrl_next = ctrl_reg & ~(wbits & lcr_pkg::CTRL_CLEAR_MASK);
      if (overlong_cycle_flag_i)
         ctrl_next[lcr_pkg::BIT_ROOT] = 1'b0;
      if (global_reset_signal_i)
         ctrl_next[lcr_pkg::BIT_SYNC_LOCK] = 1'b0;
      cstart_next = rollover & ctrl_reg[lcr_pkg::BIT_ROOT];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_reg <= lcr_pkg::CTRL_RESET;
         cstart_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         cstart_reg <= cstart_next;
      end
   end

   // ****************************************
   // Cycle timer
   // ****************************************
   lcr_cycle_timer #(
      .ROLL_TICKS(lcr_pkg::CYCLE_TICKS)
   ) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(cycle_tick_i),
      .count_enable_i(ctrl_reg[lcr_pkg::BIT_COUNT_EN]),
      .ext_select_i(ctrl_reg[lcr_pkg::BIT_EXT_SELECT]),
      .ext_cycle_i(external_cycle_input_i),
      .offset_o(cycle_offset_o),
      .rollover_o(rollover)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   assign channels_available_lo_o = csr_reg;
   assign priority_limit_o = fair_reg;
   assign priority_request_allowed_o = allow_reg;
   assign external_rollover_select_o = ctrl_reg[lcr_pkg::BIT_EXT_SELECT];
   assign root_cycle_generator_o = ctrl_reg[lcr_pkg::BIT_ROOT];
   assign cycle_count_enable_o = ctrl_reg[lcr_pkg::BIT_COUNT_EN];
   assign accept_phy_packets_o = ctrl_reg[lcr_pkg::BIT_PHY_PKT];
   assign accept_self_id_packets_o = ctrl_reg[lcr_pkg::BIT_SELF_ID];
   assign sync_filter_lock_o = ctrl_reg[lcr_pkg::BIT_SYNC_LOCK];
   assign cycle_start_o = cstart_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence wr_at(logic [7:0] ofs);
      wr_take && hit(wb_adr_i, ofs);
   endsequence

   sequence no_mask_write;
      !(wr_take && hit(wb_adr_i, lcr_pkg::OFS_CHAN_MASK_LO)) && !soft_reset_i;
   endsequence

   mask_soft_reset_a: assert property (soft_reset_i |=> mask_reg == 32'hFFFF_FFFF)
      else $error("Channel mask not all ones after soft reset");

   mask_keeps_a: assert property (serial_bus_reset_i and no_mask_write |=> $stable(mask_reg))
      else $error("Channel mask changed on serial bus reset");

   csr_copy_a: assert property (host_bus_reset_i || serial_bus_reset_i |=> csr_reg == $past(mask_reg))
      else $error("CSR copy does not match channel mask");

   fair_read_a: assert property (ack_next && hit(wb_adr_i, lcr_pkg::OFS_FAIRNESS) ##1 wb_ack_o
      |-> wb_dat_o[31:8] == 24'h00_0000 && wb_dat_o[7:0] == fair_reg)
      else $error("Fairness read shows reserved bits or wrong value");

   prio_cap_a: assert property (pcount_reg <= fair_reg || $past(fair_reg) != fair_reg
      || !$past(allow_reg))
      else $error("Priority requests exceeded the limit");

   ctrl_set_clear_a: assert property (wr_at(lcr_pkg::OFS_CTRL_SET) and !overlong_cycle_flag_i
      && !global_reset_signal_i |=> ctrl_reg == ($past(ctrl_reg) | ($past(wbits) & 32'h0070_0640)))
      else $error("Set port did not set the written bits");

   ctrl_clear_a: assert property (wr_at(lcr_pkg::OFS_CTRL_CLEAR) and !global_reset_signal_i
      |=> (ctrl_reg & $past(wbits) & 32'h0070_0600) == 32'h0000_0000)
      else $error("Clear port left written bits set");

   ctrl_reserved_a: assert property ((ctrl_reg & 32'hFF8F_F9BF) == 32'h0000_0000)
      else $error("Reserved link control bit is set");

   ctrl_read_a: assert property (ack_next && hit(wb_adr_i, lcr_pkg::OFS_CTRL_CLEAR)
      |=> wb_ack_o && wb_dat_o == $past(ctrl_reg))
      else $error("Clear address read did not return control");

   root_blocked_a: assert property (overlong_cycle_flag_i |=> !root_cycle_generator_o)
      else $error("Root bit set while overlong cycle flag high");

   lock_global_reset_signal_a: assert property (global_reset_signal_i |=> !sync_filter_lock_o)
      else $error("Sync filter lock survived global reset");

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Ack held for more than one cycle");
endmodule

// ---- hdl/lcr_pkg.sv ----
// Package of offsets, field positions, reset values and timing for the link configuration registers
package lcr_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_CHAN_MASK_LO = 8'hB8;
   localparam logic [7:0] OFS_FAIRNESS = 8'hDC;
   localparam logic [7:0] OFS_CTRL_SET = 8'hE0;
   localparam logic [7:0] OFS_CTRL_CLEAR = 8'hE4;

   // ****************************************
   // Reset values and field masks
   // ****************************************
   localparam logic [31:0] CHAN_MASK_RESET = 32'hFFFF_FFFF;
   localparam logic [7:0] FAIRNESS_RESET = 8'h00;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_SET_MASK = 32'h0070_0640;
   localparam logic [31:0] CTRL_CLEAR_MASK = 32'h0070_0600;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // ****************************************
   // Link control bit positions
   // ****************************************
   localparam int BIT_EXT_SELECT = 22;
   localparam int BIT_ROOT = 21;
   localparam int BIT_COUNT_EN = 20;
   localparam int BIT_PHY_PKT = 10;
   localparam int BIT_SELF_ID = 9;
   localparam int BIT_SYNC_LOCK = 6;

   // ****************************************
   // Cycle timer timing
   // ****************************************
   localparam longint CYCLE_PERIOD_NS = 125000;
   localparam longint CYCLE_CLK_KHZ = 24576;
   localparam int CYCLE_TICKS = int'((CYCLE_PERIOD_NS * CYCLE_CLK_KHZ) / 64'd1000000);
   localparam int OFFSET_W = 12;

endpackage

// ---- verification/lcr_link_config_tb.sv ----
// Self-checking testbench for the link configuration register bank
module lcr_link_config_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // Stimulus, observed outputs and instance
   // ****************************************
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic soft_reset_i = 1'b0, global_reset_signal_i = 1'b0, host_bus_reset_i = 1'b0, serial_bus_reset_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic overlong_cycle_flag_i = 1'b0, external_cycle_input_i = 1'b0, cycle_tick_i = 1'b0;
   logic prio_req_issued_i = 1'b0, fairness_interval_start_i = 1'b0;
   logic [31:0] wb_dat_o, channels_available_lo_o;
   logic [7:0] priority_limit_o;
   logic wb_ack_o, priority_request_allowed_o, external_rollover_select_o, root_cycle_generator_o;
   logic cycle_count_enable_o, accept_phy_packets_o, accept_self_id_packets_o, sync_filter_lock_o, cycle_start_o;
   logic [lcr_pkg::OFFSET_W-1:0] cycle_offset_o;
   int bad_count = 0;
   int n_checks = 0;
   logic [3:0] bus_sel = 4'hF;

   lcr_link_config i_lcr_link_config (
      .clk_i, .rst_i, .soft_reset_i, .global_reset_signal_i, .host_bus_reset_i, .serial_bus_reset_i,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .overlong_cycle_flag_i, .external_cycle_input_i, .cycle_tick_i, .prio_req_issued_i,
      .fairness_interval_start_i, .channels_available_lo_o, .priority_limit_o, .priority_request_allowed_o,
      .external_rollover_select_o, .root_cycle_generator_o, .cycle_count_enable_o, .accept_phy_packets_o,
      .accept_self_id_packets_o, .sync_filter_lock_o, .cycle_offset_o, .cycle_start_o
   );

   // 125 MHz clock
   always #4 clk_i = ~clk_i;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic cycle; request held until ack is sampled, then released for one idle cycle;
   // only the watchdog ends a wait, the one-cycle answer is checked afterwards
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= bus_sel;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
      begin
         @(posedge clk_i);
         n++;
      end
      check(n, 32'd1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      wb_xfer(1'b1, adr, dat, d);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      wb_xfer(1'b0, adr, 32'h0000_0000, d);
      check(d, exp);
   endtask

   // Counts edges until the next sampled cycle start pulse, bounded
   task automatic wait_start(output int cycles);
      cycles = 0;
      do
      begin
         @(posedge clk_i);
         cycles++;
      end
      while (cycle_start_o !== 1'b1 && cycles < 5000);
   endtask

   task automatic give_verdict();
      if (bad_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_values();
      rd_chk(lcr_pkg::OFS_CHAN_MASK_LO, 32'hFFFF_FFFF);
      rd_chk(lcr_pkg::OFS_FAIRNESS, 32'h0000_0000);
      rd_chk(lcr_pkg::OFS_CTRL_SET, 32'h0000_0000);
      rd_chk(8'h00, 32'h0000_0000);
      check(channels_available_lo_o, 32'hFFFF_FFFF);
   endtask

   // Each bus reset kind copies the current mask; a soft reset restores all ones
   task automatic t_mask_copy();
      wr(lcr_pkg::OFS_CHAN_MASK_LO, 32'h1234_5678);
      serial_bus_reset_i <= 1'b1;
      @(posedge clk_i);
      serial_bus_reset_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(lcr_pkg::OFS_CHAN_MASK_LO, 32'h1234_5678);
      check(channels_available_lo_o, 32'h1234_5678);
      wr(lcr_pkg::OFS_CHAN_MASK_LO, 32'hA5A5_0F0F);
      host_bus_reset_i <= 1'b1;
      @(posedge clk_i);
      host_bus_reset_i <= 1'b0;
      @(posedge clk_i);
      check(channels_available_lo_o, 32'hA5A5_0F0F);
      wr(lcr_pkg::OFS_CHAN_MASK_LO, 32'h0000_FFFF);
      global_reset_signal_i <= 1'b1;
      @(posedge clk_i);
      global_reset_signal_i <= 1'b0;
      @(posedge clk_i);
      check(channels_available_lo_o, 32'h0000_FFFF);
      soft_reset_i <= 1'b1;
      @(posedge clk_i);
      soft_reset_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(lcr_pkg::OFS_CHAN_MASK_LO, 32'hFFFF_FFFF);
   endtask

   // Limit of two requests per interval, reserved bits written as ones
   task automatic t_fairness();
      wr(lcr_pkg::OFS_FAIRNESS, 32'hFFFF_FF02);
      rd_chk(lcr_pkg::OFS_FAIRNESS, 32'h0000_0002);
      check({24'h0, priority_limit_o}, 32'h0000_0002);
      fairness_interval_start_i <= 1'b1;
      @(posedge clk_i);
      fairness_interval_start_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check({31'h0, priority_request_allowed_o}, 32'h1);
      repeat (2)
      begin
         prio_req_issued_i <= 1'b1;
         @(posedge clk_i);
         prio_req_issued_i <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
      check({31'h0, priority_request_allowed_o}, 32'h0);
      fairness_interval_start_i <= 1'b1;
      @(posedge clk_i);
      fairness_interval_start_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check({31'h0, priority_request_allowed_o}, 32'h1);
      // Limit lives in lane 0, so a write with lane 0 off changes nothing
      bus_sel = 4'hE;
      wr(lcr_pkg::OFS_FAIRNESS, 32'h0000_0077);
      rd_chk(lcr_pkg::OFS_FAIRNESS, 32'h0000_0002);
      // Mask writes honour byte lanes
      bus_sel = 4'h1;
      wr(lcr_pkg::OFS_CHAN_MASK_LO, 32'h0000_0000);
      bus_sel = 4'hF;
      rd_chk(lcr_pkg::OFS_CHAN_MASK_LO, 32'hFFFF_FF00);
   endtask

   // Mid-run system reset brings every register back to its reset value
   task automatic t_mid_reset();
      wr(lcr_pkg::OFS_CHAN_MASK_LO, 32'h0000_1111);
      wr(lcr_pkg::OFS_FAIRNESS, 32'h0000_0005);
      wr(lcr_pkg::OFS_CTRL_SET, 32'h0000_0600);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(lcr_pkg::OFS_CHAN_MASK_LO, 32'hFFFF_FFFF);
      rd_chk(lcr_pkg::OFS_FAIRNESS, 32'h0000_0000);
      rd_chk(lcr_pkg::OFS_CTRL_CLEAR, 32'h0000_0000);
      check({24'h0, priority_limit_o}, 32'h0000_0000);
   endtask

   task automatic t_control();
      wr(lcr_pkg::OFS_CTRL_SET, 32'hFFFF_FFFF);
      rd_chk(lcr_pkg::OFS_CTRL_CLEAR, 32'h0070_0640);
      check({26'h0, external_rollover_select_o, root_cycle_generator_o, cycle_count_enable_o,
             accept_phy_packets_o, accept_self_id_packets_o, sync_filter_lock_o}, 32'h0000_003F);
      wr(lcr_pkg::OFS_CTRL_CLEAR, 32'hFFFF_FFFF);
      rd_chk(lcr_pkg::OFS_CTRL_SET, 32'h0000_0040);
      wr(lcr_pkg::OFS_CTRL_SET, 32'h0000_0200);
      rd_chk(lcr_pkg::OFS_CTRL_SET, 32'h0000_0240);
      global_reset_signal_i <= 1'b1;
      @(posedge clk_i);
      global_reset_signal_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(lcr_pkg::OFS_CTRL_SET, 32'h0000_0200);
      check({31'h0, sync_filter_lock_o}, 32'h0);
      wr(lcr_pkg::OFS_CTRL_SET, 32'h0020_0000);
      rd_chk(lcr_pkg::OFS_CTRL_SET, 32'h0020_0200);
      // Overlong flag knocks the root bit down and keeps it down
      overlong_cycle_flag_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check({31'h0, root_cycle_generator_o}, 32'h0);
      wr(lcr_pkg::OFS_CTRL_SET, 32'h0020_0000);
      rd_chk(lcr_pkg::OFS_CTRL_SET, 32'h0000_0200);
      overlong_cycle_flag_i <= 1'b0;
      wr(lcr_pkg::OFS_CTRL_CLEAR, 32'h0000_0200);
   endtask

   // Internal rollover period, counting hold and external rollover
   task automatic t_timer();
      int n;
      logic [31:0] held;
      cycle_tick_i <= 1'b1;
      wr(lcr_pkg::OFS_CTRL_SET, 32'h0030_0000);
      wait_start(n);
      wait_start(n);
      check(n, 32'd3072);
      wr(lcr_pkg::OFS_CTRL_CLEAR, 32'h0010_0000);
      repeat (2) @(posedge clk_i);
      held = {20'h0, cycle_offset_o};
      repeat (20) @(posedge clk_i);
      check({20'h0, cycle_offset_o}, held);
      wr(lcr_pkg::OFS_CTRL_SET, 32'h0050_0000);
      repeat (10) @(posedge clk_i);
      cycle_tick_i <= 1'b0;
      @(posedge clk_i);
      external_cycle_input_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      check({20'h0, cycle_offset_o}, 32'h0000_0000);
      external_cycle_input_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset_values();
      t_mask_copy();
      t_fairness();
      t_control();
      t_mid_reset();
      t_timer();
      give_verdict();
   end

   // Tests need under 8000 cycles; 30000 leaves ample margin
   initial
   begin
      #(8 * 30000);
      bad_count++;
      give_verdict();
   end
endmodule
